/* srcdet_pkg.sv */
/*
  Constants and types for the input source type detector.
  Assumes a 50 MHz mclk; current limits are held in 10 mA steps.
*/
package srcdet_pkg;
  localparam int CLK_MHZ        = 50;
  localparam int SETTLE_US      = 40;
  localparam int DCD_TIMEOUT_US = 60;
  localparam int HV_TIMEOUT_US  = 80;
  localparam logic [11:0] SETTLE_CNT = 12'(SETTLE_US * CLK_MHZ);
  localparam logic [11:0] DCD_CNT    = 12'(DCD_TIMEOUT_US * CLK_MHZ);
  localparam logic [11:0] HV_CNT     = 12'(HV_TIMEOUT_US * CLK_MHZ);
  // register offsets
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_ILIM  = 4'h1;
  localparam logic [3:0] ADDR_STAT  = 4'h2;
  localparam logic [3:0] ADDR_FLAG  = 4'h3;
  localparam logic [3:0] ADDR_DRIVE = 4'h4;
  localparam logic [3:0] ADDR_DPADC = 4'h5;
  localparam logic [3:0] ADDR_DMADC = 4'h6;
  localparam logic [3:0] ADDR_EFF   = 4'h7;
  // control bit positions and reset value
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_HV   = 1;
  localparam int CTRL_9V   = 2;
  localparam int CTRL_12V  = 3;
  localparam int CTRL_EXT  = 4;
  localparam int CTRL_BCM  = 5;
  localparam int CTRL_DLM  = 6;
  localparam logic [7:0] CTRL_RST = 8'h11;
  // limits in 10 mA steps
  localparam logic [9:0] LIM_SDP  = 10'h032;
  localparam logic [9:0] LIM_CDP  = 10'h096;
  localparam logic [9:0] LIM_DCP  = 10'h145;
  localparam logic [9:0] LIM_HV   = 10'h096;
  localparam logic [9:0] LIM_UNK  = 10'h12C;
  localparam logic [9:0] LIM_DEF  = 10'h12C;
  localparam logic [9:0] LIM_DIV1 = 10'h0D2;
  localparam logic [9:0] LIM_DIV2 = 10'h0C8;
  localparam logic [9:0] LIM_DIV3 = 10'h064;
  localparam logic [9:0] LIM_DIV4 = 10'h0F0;
  // source type codes
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_SDP  = 4'h1;
  localparam logic [3:0] SRC_CDP  = 4'h2;
  localparam logic [3:0] SRC_DCP  = 4'h3;
  localparam logic [3:0] SRC_HV   = 4'h4;
  localparam logic [3:0] SRC_UNK  = 4'h5;
  localparam logic [3:0] SRC_NSTD = 4'h6;
  // drive levels: D+ 0 hiz,1 0V,2 0.6,3 1.2,4 2.0,5 2.7,6 3.3,7 short
  // D- 0 hiz,1 0.6,2 1.2,3 2.0,4 2.7,5 3.3
  localparam logic [2:0] DRV_HIZ = 3'h0;
  localparam logic [2:0] DM_LAST = 3'h5;
  // high-voltage request codes
  localparam logic [1:0] HV_NONE = 2'h0;
  localparam logic [1:0] HV_9    = 2'h1;
  localparam logic [1:0] HV_12   = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_LOAD = 4'b0001,
    ST_DCD  = 4'b0010,
    ST_PRI  = 4'b0011,
    ST_NSTD = 4'b0100,
    ST_SEC  = 4'b0101,
    ST_BCD  = 4'b0110,
    ST_HVRQ = 4'b0111,
    ST_FIN  = 4'b1000
  } det_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic dp_2p8;
    logic dp_2p0;
    logic dp_1p2;
    logic dm_2p8;
    logic dm_2p0;
    logic dm_1p2;
  } window_t;
endpackage

/* srcdet_core.sv */
/*
  Input source type detector: runs the D+/D- classification sequence
  after the input is qualified, sets the current limit and type code,
  raises done flags, and drives host-selected D+/D- levels.
  Assumes analog comparators, ADC readings and the limit pin clamp arrive
  as synchronous inputs, and a plain register port from the host side.
*/
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module srcdet_core
  import srcdet_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire bus_req_t    bus,
  output logic      [15:0] rdata,
  input  wire logic        source_qualified,
  input  wire logic        first_input_sense,
  input  wire logic        data_contact,
  input  wire logic        primary_charger,
  input  wire logic        secondary_dcp,
  input  wire window_t     win,
  input  wire logic        hv_ack,
  input  wire logic [9:0]  limit_clamp,
  input  wire logic [15:0] adc_dplus,
  input  wire logic [15:0] adc_dminus,
  output logic             host_alert,
  output logic      [9:0]  input_limit_eff,
  output logic      [2:0]  dplus_drive,
  output logic      [2:0]  dminus_drive,
  output logic      [3:0]  probe_step,
  output logic      [1:0]  hv_request
);
  typedef struct packed {
    det_state_t  state;
    logic [11:0] timer;
    logic [7:0]  ctrl;
    logic [9:0]  ilim;
    logic [3:0]  src_code;
    logic        bc_status;
    logic        dl_status;
    logic        pg_status;
    logic        bc_flag;
    logic        dl_flag;
    logic [2:0]  dp_level;
    logic [2:0]  dm_level;
    logic [3:0]  pend_code;
    logic [9:0]  pend_lim;
    logic        dcd_timeout;
    logic        hv_twelve;
    logic [1:0]  hv_req;
    logic        qual_seen;
    logic        alert;
    logic [9:0]  eff;
    logic [2:0]  dp_drive;
    logic [2:0]  dm_drive;
    logic [15:0] rdata;
  } core_t;

  core_t st;
  core_t next_st;
  logic  bc_set;
  logic  dl_set;
  logic  drive_locked;
  logic  settled;

  // hold a value at or below the limit pin clamp when the pin is enabled
  function automatic logic [9:0] clamp_lim(input logic [9:0] v,
                                           input logic       en,
                                           input logic [9:0] c);
    clamp_lim = (en && v > c) ? c : v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state: register port, sequencer, outputs
  always_comb
  begin
    next_st = st;
    next_st.alert = 1'b0;
    next_st.rdata = 16'h0000;
    bc_set = 1'b0;
    dl_set = 1'b0;
    drive_locked = first_input_sense && (st.state != ST_IDLE);
    settled = (st.timer == SETTLE_CNT - 12'h001);

    // host writes
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_CTRL: next_st.ctrl = bus.wdata[7:0];
        ADDR_ILIM: next_st.ilim = clamp_lim(bus.wdata[9:0],
                                            st.ctrl[CTRL_EXT],
                                            limit_clamp);
        ADDR_DRIVE:
        begin
          if (!drive_locked)
          begin
            next_st.dp_level = bus.wdata[2:0];
            if (bus.wdata[6:4] <= DM_LAST)
              next_st.dm_level = bus.wdata[6:4];
          end
        end
        default: ;
      endcase
    end

    // reading the flag register clears it
    if (bus.rd && bus.addr == ADDR_FLAG)
    begin
      next_st.bc_flag = 1'b0;
      next_st.dl_flag = 1'b0;
    end

    // classification sequencer
    if (!source_qualified)
    begin
      next_st.state = ST_IDLE;
      next_st.qual_seen = 1'b0;
      next_st.pg_status = 1'b0;
      next_st.hv_req = HV_NONE;
      next_st.timer = 12'h000;
    end
    else
    begin
      case (st.state)
        ST_IDLE:
        begin
          if (!st.qual_seen)
          begin
            next_st.qual_seen = 1'b1;
            next_st.pg_status = 1'b1;
            if (st.ctrl[CTRL_AUTO] && first_input_sense)
              next_st.state = ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          // clear the last result, load the default limit
          next_st.src_code = SRC_NONE;
          next_st.bc_status = 1'b0;
          next_st.dl_status = 1'b1;
          next_st.ilim = clamp_lim(LIM_DEF, st.ctrl[CTRL_EXT],
                                   limit_clamp);
          next_st.timer = 12'h000;
          next_st.state = ST_DCD;
        end
        ST_DCD:
        begin
          next_st.timer = st.timer + 12'h001;
          if (data_contact && st.timer >= SETTLE_CNT - 12'h001)
          begin
            next_st.dcd_timeout = 1'b0;
            next_st.timer = 12'h000;
            next_st.state = ST_PRI;
          end
          else if (st.timer == DCD_CNT - 12'h001)
          begin
            next_st.dcd_timeout = 1'b1;
            next_st.timer = 12'h000;
            next_st.state = ST_PRI;
          end
        end
        ST_PRI:
        begin
          next_st.timer = st.timer + 12'h001;
          if (settled)
          begin
            next_st.timer = 12'h000;
            // standard check first, dividers only if it fails
            next_st.state = primary_charger ? ST_SEC : ST_NSTD;
          end
        end
        ST_NSTD:
        begin
          next_st.timer = st.timer + 12'h001;
          if (settled)
          begin
            next_st.timer = 12'h000;
            next_st.state = ST_BCD;
            next_st.pend_code = SRC_NSTD;
            if (win.dp_2p8 && win.dm_2p0)
              next_st.pend_lim = LIM_DIV1;
            else if (win.dp_1p2 && win.dm_1p2)
              next_st.pend_lim = LIM_DIV2;
            else if (win.dp_2p0 && win.dm_2p8)
              next_st.pend_lim = LIM_DIV3;
            else if (win.dp_2p8 && win.dm_2p8)
              next_st.pend_lim = LIM_DIV4;
            else if (st.dcd_timeout)
            begin
              next_st.pend_code = SRC_UNK;
              next_st.pend_lim = LIM_UNK;
            end
            else
            begin
              next_st.pend_code = SRC_SDP;
              next_st.pend_lim = LIM_SDP;
            end
          end
        end
        ST_SEC:
        begin
          next_st.timer = st.timer + 12'h001;
          if (settled)
          begin
            next_st.timer = 12'h000;
            next_st.state = ST_BCD;
            if (secondary_dcp)
            begin
              next_st.pend_code = SRC_DCP;
              next_st.pend_lim = LIM_DCP;
            end
            else
            begin
              next_st.pend_code = SRC_CDP;
              next_st.pend_lim = LIM_CDP;
            end
          end
        end
        ST_BCD:
        begin
          next_st.src_code = st.pend_code;
          next_st.ilim = clamp_lim(st.pend_lim, st.ctrl[CTRL_EXT],
                                   limit_clamp);
          next_st.bc_status = 1'b1;
          bc_set = 1'b1;
          next_st.timer = 12'h000;
          next_st.state = ST_FIN;
          if (st.pend_code == SRC_DCP && st.ctrl[CTRL_HV] &&
              (st.ctrl[CTRL_9V] || st.ctrl[CTRL_12V]))
          begin
            next_st.hv_twelve = st.ctrl[CTRL_12V];
            next_st.hv_req = st.ctrl[CTRL_12V] ? HV_12 : HV_9;
            next_st.state = ST_HVRQ;
          end
        end
        ST_HVRQ:
        begin
          next_st.timer = st.timer + 12'h001;
          if (hv_ack)
          begin
            next_st.src_code = SRC_HV;
            next_st.ilim = clamp_lim(LIM_HV, st.ctrl[CTRL_EXT],
                                     limit_clamp);
            next_st.state = ST_FIN;
          end
          else if (st.timer == HV_CNT - 12'h001)
          begin
            next_st.timer = 12'h000;
            if (st.hv_twelve && st.ctrl[CTRL_9V])
            begin
              // 12 V refused, fall back to 9 V
              next_st.hv_twelve = 1'b0;
              next_st.hv_req = HV_9;
            end
            else
            begin
              next_st.hv_req = HV_NONE;
              next_st.state = ST_FIN;
            end
          end
        end
        ST_FIN:
        begin
          next_st.dl_status = 1'b0;
          dl_set = 1'b1;
          next_st.state = ST_IDLE;
        end
        default: next_st.state = ST_IDLE;
      endcase
    end

    // flags: a set beats a clear in the same cycle
    next_st.bc_flag = next_st.bc_flag | bc_set;
    next_st.dl_flag = next_st.dl_flag | dl_set;
    next_st.alert = (bc_set && !st.ctrl[CTRL_BCM]) ||
                    (dl_set && !st.ctrl[CTRL_DLM]);

    // effective limit and pin drive
    next_st.eff = clamp_lim(st.ilim, st.ctrl[CTRL_EXT], limit_clamp);
    next_st.dp_drive = first_input_sense ? st.dp_level : DRV_HIZ;
    next_st.dm_drive = first_input_sense ? st.dm_level : DRV_HIZ;

    // read data, valid the cycle after the strobe
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CTRL:  next_st.rdata = {8'h00, st.ctrl};
        ADDR_ILIM:  next_st.rdata = {6'h00, st.ilim};
        ADDR_STAT:  next_st.rdata = {9'h000, st.pg_status, st.dl_status,
                                     st.bc_status, st.src_code};
        ADDR_FLAG:  next_st.rdata = {14'h0000, st.dl_flag, st.bc_flag};
        ADDR_DRIVE: next_st.rdata = {9'h000, st.dm_level, 1'b0,
                                     st.dp_level};
        ADDR_DPADC: next_st.rdata = adc_dplus;
        ADDR_DMADC: next_st.rdata = adc_dminus;
        ADDR_EFF:   next_st.rdata = {6'h00, st.eff};
        default:    next_st.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.state <= ST_IDLE;
      st.ctrl <= CTRL_RST;
      st.ilim <= LIM_DEF;
      st.eff <= LIM_DEF;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign rdata = st.rdata;
  assign host_alert = st.alert;
  assign input_limit_eff = st.eff;
  assign dplus_drive = st.dp_drive;
  assign dminus_drive = st.dm_drive;
  assign probe_step = st.state;
  assign hv_request = st.hv_req;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_start_gate: assert property (
    st.state == ST_LOAD |-> $past(st.ctrl[CTRL_AUTO]) && st.pg_status)
    else $error("classification started without enable");

  chk_bc_done: assert property (
    st.state == ST_BCD |=> st.bc_status && st.bc_flag &&
      (host_alert == !$past(st.ctrl[CTRL_BCM])))
    else $error("bc done status, flag or alert wrong");

  chk_hv_gate: assert property (
    $rose(st.state == ST_HVRQ) |-> st.src_code == SRC_DCP &&
      $past(st.ctrl[CTRL_HV]))
    else $error("handshake begun without DCP or enable");

  chk_eff_limit: assert property (
    ##1 input_limit_eff == (($past(st.ctrl[CTRL_EXT]) &&
      $past(st.ilim) > $past(limit_clamp)) ? $past(limit_clamp) :
      $past(st.ilim)))
    else $error("effective limit not the lower value");

  chk_skip_detect: assert property (
    st.state == ST_IDLE && !st.ctrl[CTRL_AUTO] |=> st.state == ST_IDLE)
    else $error("classification ran while disabled");

  chk_step_order: assert property (
    st.state == ST_DCD |=> st.state inside {ST_DCD, ST_PRI, ST_IDLE})
    else $error("contact detect not followed by primary");

  chk_dl_done: assert property (
    st.state == ST_FIN |=> !st.dl_status && st.dl_flag &&
      (host_alert == !$past(st.ctrl[CTRL_DLM])))
    else $error("dataline done status or flag wrong");

  chk_drive_lock: assert property (
    drive_locked && bus.wr && bus.addr == ADDR_DRIVE |=>
      st.dp_level == $past(st.dp_level))
    else $error("drive level changed while classifying");

  chk_limit_clamp: assert property (
    st.state == ST_BCD && st.ctrl[CTRL_EXT] |=>
      st.ilim <= $past(limit_clamp))
    else $error("classified limit above clamp");
endmodule

/* usb_port_model.sv */
/*
  Behavioural USB charging port for the source type detector bench.
  Assumes the bench picks the port kind and toggles qualification itself.
*/
`timescale 1ns/1ps
module usb_port_model
  import srcdet_pkg::*;
#(
  parameter logic [15:0] DP_READ = 16'h0A5C,
  parameter logic [15:0] DM_READ = 16'h05A3
)
(
  input  wire logic        mclk,
  input  wire logic [3:0]  kind,
  input  wire logic [1:0]  hv_request,
  output logic             data_contact,
  output logic             primary_charger,
  output logic             secondary_dcp,
  output window_t          win,
  output logic             hv_ack,
  output logic      [15:0] adc_dplus,
  output logic      [15:0] adc_dminus
);
  ////////////////////////////////////////////////////////////////////////
  // kinds: 0 sdp, 1 cdp, 2 dcp, 3 high-voltage dcp, 4-7 dividers, 8 none
  logic [7:0] ack_cnt = 8'h00;

  // comparator levels follow the chosen port kind
  // a cdp stays a cdp: every run ends far inside the enumeration window
  always_comb
  begin
    data_contact    = (kind != 4'h8);
    primary_charger = (kind inside {4'h1, 4'h2, 4'h3});
    secondary_dcp   = (kind inside {4'h2, 4'h3});
    case (kind)
      4'h4:    win = 6'h22;
      4'h5:    win = 6'h09;
      4'h6:    win = 6'h14;
      4'h7:    win = 6'h24;
      default: win = 6'h00;
    endcase
  end

  // a slow adapter accepts any voltage request after 100 cycles
  always_ff @(posedge mclk)
    if (kind != 4'h3 || hv_request == HV_NONE)
      ack_cnt <= 8'h00;
    else if (ack_cnt != 8'h64)
      ack_cnt <= ack_cnt + 8'h01;

  assign hv_ack     = (ack_cnt == 8'h64);
  assign adc_dplus  = DP_READ;
  assign adc_dminus = DM_READ;
endmodule

/* tb_top.sv */
/*
  Self-checking bench for the source type detector.
  Assumes the port model answers the data lines and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
  import srcdet_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  bus_req_t    bus;
  logic        qual;
  logic        first_sense;
  logic [3:0]  kind;
  logic [9:0]  clamp;
  logic [15:0] rdata;
  logic        dc;
  logic        pc;
  logic        sd;
  window_t     win;
  logic        ack;
  logic [15:0] adp;
  logic [15:0] adm;
  logic        host_alert;
  logic [9:0]  eff;
  logic [2:0]  dpd;
  logic [2:0]  dmd;
  logic [3:0]  probe_step;
  logic [1:0]  hv_request;
  logic [1:0]  first_hv;
  int          errors;
  int          n_compared;
  int          n_alert;

  srcdet_core u_srcdet_core (.mclk(mclk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .source_qualified(qual), .first_input_sense(first_sense),
    .data_contact(dc), .primary_charger(pc), .secondary_dcp(sd), .win(win),
    .hv_ack(ack), .limit_clamp(clamp), .adc_dplus(adp), .adc_dminus(adm),
    .host_alert(host_alert), .input_limit_eff(eff), .dplus_drive(dpd),
    .dminus_drive(dmd), .probe_step(probe_step), .hv_request(hv_request));

  usb_port_model u_usb_port_model (.mclk(mclk), .kind(kind),
    .hv_request(hv_request), .data_contact(dc), .primary_charger(pc),
    .secondary_dcp(sd), .win(win), .hv_ack(ack), .adc_dplus(adp),
    .adc_dminus(adm));

  ////////////////////////////////////////////////////////////////////////
  // clock, alert count and first voltage request seen
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (host_alert === 1'b1)
      n_alert++;
    if (first_hv === HV_NONE && hv_request !== HV_NONE)
      first_hv <= hv_request;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared bus and compare tasks
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [3:0] a,
                    input logic [15:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  // drop then raise qualification, as a fresh attachment
  task automatic attach(input logic [3:0] k);
    @(posedge mclk);
    kind <= k;
    qual <= 1'b0;
    repeat (2) @(posedge mclk);
    // clear only once the dropped request has left hv_request
    n_alert = 0;
    first_hv = HV_NONE;
    qual <= 1'b1;
  endtask

  task automatic wait_fin();
    int i;
    for (i = 0; i < 20000 && probe_step !== ST_FIN; i++)
      @(posedge mclk) #1;
    if (i == 20000)
    begin
      errors++;
      close_out();
    end
    repeat (3) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd("ctrl", ADDR_CTRL, 16'h0011);
    rd("ilim", ADDR_ILIM, 16'h012C);
    rd("unmapped", 4'hF, 16'h0000);
    check("eff", 16'(eff), 16'h012C);
  endtask

  task automatic t_types();
    logic [3:0] k [8] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [3:0] c [8] = '{SRC_SDP, SRC_CDP, SRC_DCP, SRC_UNK,
                          SRC_NSTD, SRC_NSTD, SRC_NSTD, SRC_NSTD};
    logic [9:0] l [8] = '{LIM_SDP, LIM_CDP, LIM_DCP, LIM_UNK,
                          LIM_DIV1, LIM_DIV2, LIM_DIV3, LIM_DIV4};
    for (int i = 0; i < 8; i++)
    begin
      attach(k[i]);
      wait_fin();
      rd("stat", ADDR_STAT, 16'h0050 | 16'(c[i]));
      rd("ilim", ADDR_ILIM, 16'(l[i]));
      rd("flag", ADDR_FLAG, 16'h0003);
      check("alerts", 16'(n_alert), 16'h0002);
      check("hv req", 16'(first_hv), 16'(HV_NONE));
    end
  endtask

  task automatic t_mask();
    wr(ADDR_CTRL, 16'h0061);
    attach(4'h0);
    wait_fin();
    check("alerts", 16'(n_alert), 16'h0000);
    rd("flag", ADDR_FLAG, 16'h0003);
    rd("flag", ADDR_FLAG, 16'h0000);
  endtask

  task automatic t_hv();
    logic [15:0] ctl [2] = '{16'h000F, 16'h0007};
    logic [1:0]  req [2] = '{HV_12, HV_9};
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL, ctl[i]);
      attach(4'h3);
      wait_fin();
      check("hv req", 16'(first_hv), 16'(req[i]));
      rd("stat", ADDR_STAT, 16'h0054);
      rd("ilim", ADDR_ILIM, 16'(LIM_HV));
    end
    wr(ADDR_CTRL, 16'h0001);
  endtask

  task automatic t_auto_off();
    wr(ADDR_ILIM, 16'h00AB);
    wr(ADDR_CTRL, 16'h0000);
    attach(4'h2);
    // look mid-way, while an enabled run would still be busy
    repeat (3000) @(posedge mclk);
    check("step", 16'(probe_step), 16'(ST_IDLE));
    rd("ilim", ADDR_ILIM, 16'h00AB);
    // earlier result stays: no steps ran to clear it
    rd("stat", ADDR_STAT, 16'h0054);
    wr(ADDR_CTRL, 16'h0001);
  endtask

  task automatic t_clamp();
    clamp <= 10'h064;
    wr(ADDR_CTRL, 16'h0011);
    attach(4'h2);
    wait_fin();
    rd("ilim", ADDR_ILIM, 16'h0064);
    check("eff", 16'(eff), 16'h0064);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_ILIM, 16'h0200);
    repeat (2) @(posedge mclk) #1;
    check("eff", 16'(eff), 16'h0200);
    wr(ADDR_CTRL, 16'h0011);
    repeat (2) @(posedge mclk) #1;
    check("eff", 16'(eff), 16'h0064);
    wr(ADDR_CTRL, 16'h0001);
    clamp <= 10'h3FF;
  endtask

  task automatic t_drive();
    first_sense <= 1'b0;
    attach(4'h0);
    repeat (20) @(posedge mclk) #1;
    check("step", 16'(probe_step), 16'(ST_IDLE));
    @(posedge mclk) first_sense <= 1'b1;
    attach(4'h0);
    repeat (20) @(posedge mclk);
    rd("stat", ADDR_STAT, 16'h0060);
    wr(ADDR_DRIVE, 16'h0053);
    repeat (2) @(posedge mclk) #1;
    check("dp busy", 16'(dpd), 16'h0000);
    wait_fin();
    wr(ADDR_DRIVE, 16'h0053);
    repeat (2) @(posedge mclk) #1;
    check("dp", 16'({dmd, dpd}), 16'h002B);
    wr(ADDR_DRIVE, 16'h0062);
    repeat (2) @(posedge mclk) #1;
    check("dm odd", 16'({dmd, dpd}), 16'h002A);
    @(posedge mclk) first_sense <= 1'b0;
    repeat (2) @(posedge mclk) #1;
    check("dp off", 16'({dmd, dpd}), 16'h0000);
    @(posedge mclk) first_sense <= 1'b1;
    rd("dp adc", ADDR_DPADC, 16'h0A5C);
    rd("dm adc", ADDR_DMADC, 16'h05A3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    qual = 1'b0;
    first_sense = 1'b1;
    kind = 4'h0;
    clamp = 10'h3FF;
    first_hv = HV_NONE;
    errors = 0;
    n_compared = 0;
    n_alert = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_types();
    t_mask();
    wr(ADDR_CTRL, 16'h0001);
    t_hv();
    t_auto_off();
    t_clamp();
    t_drive();
    close_out();
  end
endmodule
